// [rtl/sepd_defines.svh]
/*
 * Constants of the serial memory slave: status bit positions, reset values and timing counts.
 * Assumes a 25 MHz core clock; every count is derived from a time in nanoseconds.
 */
`ifndef SEPD_DEFINES_SVH
`define SEPD_DEFINES_SVH

// ----------------------------------------------------------------------------
// Clock
// ----------------------------------------------------------------------------
`define SEPD_CLK_NS 40

// ----------------------------------------------------------------------------
// Status byte layout
// ----------------------------------------------------------------------------
`define SEPD_BUSY_BIT 0
`define SEPD_LATCH_BIT 1
`define SEPD_PROT_LO_BIT 2
`define SEPD_PROT_HI_BIT 3
`define SEPD_PIN_GATE_BIT 7
`define SEPD_STATUS_RST 8'h00

// ----------------------------------------------------------------------------
// Serial framing
// ----------------------------------------------------------------------------
`define SEPD_OPC_BITS 6'h08
`define SEPD_WRSR_BITS 6'h10
`define SEPD_SIG_LAST 6'h17
`define SEPD_CNT_MAX 6'h3f
// Synchroniser reset: protect pin high, chip select low, so no select edge is invented
`define SEPD_SYNC_RST 4'h8

// ----------------------------------------------------------------------------
// Times (ns) and least cycle counts, rounded up
// ----------------------------------------------------------------------------
`define SEPD_RELEASE_NS 1000
`define SEPD_SETTLE_NS 1000
`define SEPD_WR_NS 5000
`define SEPD_RELEASE_CYC ((`SEPD_RELEASE_NS + `SEPD_CLK_NS - 1) / `SEPD_CLK_NS)
`define SEPD_SETTLE_CYC ((`SEPD_SETTLE_NS + `SEPD_CLK_NS - 1) / `SEPD_CLK_NS)
`define SEPD_WR_CYC ((`SEPD_WR_NS + `SEPD_CLK_NS - 1) / `SEPD_CLK_NS)

`endif

// [rtl/sepd_pkg.sv]
/*
 * Types of the serial memory slave: serial phase and internal engine states.
 * Assumes nothing beyond a SystemVerilog elaborator.
 */
package sepd_pkg;

	// ------------------------------------------------------------------------
	// Serial phase, one-hot
	// ------------------------------------------------------------------------
	typedef enum logic [3:0] {
		SP_IDLE = 4'b0001,
		SP_SHIFT = 4'b0010,
		SP_OUT = 4'b0100,
		SP_SKIP = 4'b1000
	} sepd_phase_type;

	// ------------------------------------------------------------------------
	// Internal engine, one-hot
	// ------------------------------------------------------------------------
	typedef enum logic [4:0] {
		EN_IDLE = 5'b00001,
		EN_ERASE = 5'b00010,
		EN_STATUS = 5'b00100,
		EN_SETTLE = 5'b01000,
		EN_RELEASE = 5'b10000
	} sepd_eng_type;

endpackage

// [rtl/sepd_pin_if.sv]
/*
 * Synchronised serial pin levels passed from the pin synchroniser to the core.
 * Assumes both ends run on the core clock.
 */
`timescale 1ns/1ns
interface sepd_pin_if;
	logic cs_n; // Chip select, low selects
	logic sck; // Serial clock level
	logic si; // Serial data in
	logic wp_n; // Write-protect pin, low protects
	modport src (output cs_n, output sck, output si, output wp_n);
	modport dst (input cs_n, input sck, input si, input wp_n);
endinterface

// [rtl/sepd_sync.sv]
/*
 * Two-flop synchroniser for the four serial pins.
 * Assumes the pins are asynchronous to clock; only the second stage leaves this module.
 */
`timescale 1ns/1ns
`include "sepd_defines.svh"
module sepd_sync (
	input wire logic clock,
	input wire logic rst,
	input wire logic cs_n_pin,
	input wire logic sck_pin,
	input wire logic si_pin,
	input wire logic wp_n_pin,
	sepd_pin_if.src pins
);
	logic [3:0] meta_r; // First stage, read only by the second
	logic [3:0] meta_nxt;
	logic [3:0] stab_r; // Second stage, safe to use
	logic [3:0] stab_nxt;

	// Next values: shift the pin levels through two stages
	always_comb begin
		meta_nxt = {wp_n_pin, si_pin, sck_pin, cs_n_pin};
		stab_nxt = meta_r;
	end

	// Registers; chip select resets low like the edge finder behind it,
	// so a pin held low through power-up never looks like a fresh select
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			meta_r <= `SEPD_SYNC_RST;
			stab_r <= `SEPD_SYNC_RST;
		end else begin
			meta_r <= meta_nxt;
			stab_r <= stab_nxt;
		end
	end

	assign pins.cs_n = stab_r[0];
	assign pins.sck = stab_r[1];
	assign pins.si = stab_r[2];
	assign pins.wp_n = stab_r[3];
endmodule

// [rtl/sepd_eeprom.sv]
/*
 * Serial memory slave: write enable, whole-array erase, status write and read,
 * deep power-down and signature readout with release.
 * Assumes the serial pins are asynchronous and run well below a quarter of clock.
 */
`timescale 1ns/1ns
`include "sepd_defines.svh"

module sepd_eeprom #(
	parameter logic [7:0] OPC_WRITE_EN = 8'h10, // Write enable
	parameter logic [7:0] OPC_ERASE = 8'h20, // Whole-array erase
	parameter logic [7:0] OPC_PD = 8'h30, // Deep power-down
	parameter logic [7:0] OPC_SIG = 8'h40, // Release and read signature
	parameter logic [7:0] OPC_RDSR = 8'h50, // Read status
	parameter logic [7:0] OPC_WRSR = 8'h60, // Write status
	parameter logic [7:0] SIGNATURE = 8'h5a, // Arbitrary value
	parameter int ERASE_BYTES = 65536 // Bytes swept by an erase
) (
	input wire logic clock,
	input wire logic rst,
	input wire logic cs_n_pin,
	input wire logic sck_pin,
	input wire logic si_pin,
	input wire logic wp_n_pin,
	input wire logic [15:0] peek_addr,
	output logic [7:0] peek_data,
	output logic so_o,
	output logic so_oe,
	output logic write_in_progress,
	output logic write_enable_latch,
	output logic block_protect_low,
	output logic block_protect_high,
	output logic status_write_protect_enable,
	output logic deep_powerdown,
	output logic standby
);
	// ------------------------------------------------------------------------
	// Pin synchroniser
	// ------------------------------------------------------------------------
	sepd_pin_if pins ();
	sepd_sync u_sync (
		.clock(clock),
		.rst(rst),
		.cs_n_pin(cs_n_pin),
		.sck_pin(sck_pin),
		.si_pin(si_pin),
		.wp_n_pin(wp_n_pin),
		.pins(pins)
	);

	// ------------------------------------------------------------------------
	// State
	// ------------------------------------------------------------------------
	logic [7:0] mem [0:65535]; // The array
	sepd_pkg::sepd_phase_type ph_r, ph_nxt; // Serial phase
	sepd_pkg::sepd_eng_type eng_r, eng_nxt; // Internal engine
	logic cs_d_r, cs_d_nxt; // Last chip select, resets low
	logic sck_d_r, sck_d_nxt; // Last serial clock
	logic [5:0] cnt_r, cnt_nxt; // Bits taken this selection
	logic [7:0] sh_r, sh_nxt; // Input shifter
	logic [7:0] op_r, op_nxt; // Latched opcode
	logic [7:0] out_r, out_nxt; // Byte being sent
	logic [2:0] idx_r, idx_nxt; // Bit index in out_r
	logic [7:0] wd_r, wd_nxt; // Staged status byte
	logic [15:0] tmr_r, tmr_nxt; // Engine timer
	logic [15:0] ea_r, ea_nxt; // Erase address
	logic so_r, so_nxt;
	logic oe_r, oe_nxt;
	logic latch_r, latch_nxt; // Write enable latch
	logic prot_lo_r, prot_lo_nxt; // Block protect, low bit
	logic prot_hi_r, prot_hi_nxt; // Block protect, high bit
	logic pin_gate_r, pin_gate_nxt; // Protect pin gates status writes
	logic dpd_r, dpd_nxt;
	logic busy_r, busy_nxt; // Internal write cycle running
	logic sby_r, sby_nxt;
	logic [7:0] peek_r;
	logic cs_rise, cs_fall, sck_rise, sck_fall;
	logic [7:0] opc; // Opcode completing on this edge
	logic ign; // Opcode refused
	logic [7:0] stat; // Live status byte
	logic mem_we; // Erase write strobe
	logic [7:0] mem_wd;
	logic start_erase, start_status;

	// Edge finders on the synchronised levels
	assign cs_rise = pins.cs_n & ~cs_d_r;
	assign cs_fall = ~pins.cs_n & cs_d_r;
	assign sck_rise = pins.sck & ~sck_d_r;
	assign sck_fall = ~pins.sck & sck_d_r;
	assign opc = {sh_r[6:0], pins.si};

	// ------------------------------------------------------------------------
	// Status byte and opcode acceptance
	// ------------------------------------------------------------------------
	always_comb begin
		stat = `SEPD_STATUS_RST;
		stat[`SEPD_BUSY_BIT] = busy_r;
		stat[`SEPD_LATCH_BIT] = latch_r;
		stat[`SEPD_PROT_LO_BIT] = prot_lo_r;
		stat[`SEPD_PROT_HI_BIT] = prot_hi_r;
		stat[`SEPD_PIN_GATE_BIT] = pin_gate_r;
		if (eng_r == sepd_pkg::EN_SETTLE || eng_r == sepd_pkg::EN_RELEASE) begin
			ign = 1'b1;
		end else if (dpd_r) begin
			ign = (opc != OPC_SIG);
		end else if (busy_r) begin
			ign = (opc != OPC_RDSR);
		end else begin
			ign = !(opc == OPC_WRITE_EN || opc == OPC_ERASE || opc == OPC_PD ||
				opc == OPC_SIG || opc == OPC_RDSR || opc == OPC_WRSR);
		end
	end

	// ------------------------------------------------------------------------
	// Next-state logic for serial phase, engine and status
	// ------------------------------------------------------------------------
	always_comb begin
		ph_nxt = ph_r;
		eng_nxt = eng_r;
		cs_d_nxt = pins.cs_n;
		sck_d_nxt = pins.sck;
		cnt_nxt = cnt_r;
		sh_nxt = sh_r;
		op_nxt = op_r;
		out_nxt = out_r;
		idx_nxt = idx_r;
		wd_nxt = wd_r;
		tmr_nxt = tmr_r;
		ea_nxt = ea_r;
		so_nxt = so_r;
		oe_nxt = oe_r;
		latch_nxt = latch_r;
		prot_lo_nxt = prot_lo_r;
		prot_hi_nxt = prot_hi_r;
		pin_gate_nxt = pin_gate_r;
		dpd_nxt = dpd_r;
		mem_we = 1'b0;
		mem_wd = 8'hff;
		start_erase = 1'b0;
		start_status = 1'b0;
		if (cs_rise) begin
			ph_nxt = sepd_pkg::SP_IDLE;
			oe_nxt = 1'b0;
			if (ph_r == sepd_pkg::SP_SHIFT || ph_r == sepd_pkg::SP_OUT) begin
				if (op_r == OPC_WRITE_EN && cnt_r == `SEPD_OPC_BITS) begin
					latch_nxt = 1'b1;
				end else if (op_r == OPC_ERASE && cnt_r == `SEPD_OPC_BITS) begin
					if (latch_r && !prot_lo_r && !prot_hi_r) begin
						start_erase = 1'b1;
						eng_nxt = sepd_pkg::EN_ERASE;
						ea_nxt = 16'h0000;
					end
				end else if (op_r == OPC_PD && cnt_r == `SEPD_OPC_BITS) begin
					dpd_nxt = 1'b1;
					eng_nxt = sepd_pkg::EN_SETTLE;
					tmr_nxt = 16'(`SEPD_SETTLE_CYC);
				end else if (op_r == OPC_SIG && cnt_r >= `SEPD_OPC_BITS && dpd_r) begin
					eng_nxt = sepd_pkg::EN_RELEASE;
					tmr_nxt = 16'(`SEPD_RELEASE_CYC);
				end else if (op_r == OPC_WRSR && cnt_r == `SEPD_WRSR_BITS) begin
					if (latch_r && !(pin_gate_r && !pins.wp_n)) begin
						start_status = 1'b1;
						wd_nxt = sh_r;
						eng_nxt = sepd_pkg::EN_STATUS;
						tmr_nxt = 16'(`SEPD_WR_CYC);
					end
				end
			end
		end else if (cs_fall) begin
			ph_nxt = sepd_pkg::SP_SHIFT;
			cnt_nxt = 6'h00;
		end else if (sck_rise && ph_r == sepd_pkg::SP_SHIFT) begin
			sh_nxt = opc;
			if (cnt_r != `SEPD_CNT_MAX) begin
				cnt_nxt = cnt_r + 6'h01;
			end
			if (cnt_r == `SEPD_OPC_BITS - 6'h01) begin
				op_nxt = opc;
				if (ign) begin
					ph_nxt = sepd_pkg::SP_SKIP;
				end else if (opc == OPC_RDSR) begin
					ph_nxt = sepd_pkg::SP_OUT;
					out_nxt = stat;
					idx_nxt = 3'h0;
				end
			end else if (cnt_r == `SEPD_SIG_LAST && op_r == OPC_SIG) begin
				ph_nxt = sepd_pkg::SP_OUT;
				out_nxt = SIGNATURE;
				idx_nxt = 3'h0;
			end
		end else if (sck_fall && ph_r == sepd_pkg::SP_OUT) begin
			so_nxt = out_r[3'h7 - idx_r];
			oe_nxt = 1'b1;
			idx_nxt = idx_r + 3'h1;
			if (idx_r == 3'h7) begin
				out_nxt = (op_r == OPC_RDSR) ? stat : SIGNATURE;
			end
		end
		case (eng_r)
			sepd_pkg::EN_IDLE: begin
				eng_nxt = eng_nxt;
			end
			sepd_pkg::EN_ERASE: begin
				mem_we = 1'b1;
				if (ea_r == 16'(ERASE_BYTES - 1)) begin
					eng_nxt = sepd_pkg::EN_IDLE;
					latch_nxt = 1'b0;
				end else begin
					ea_nxt = ea_r + 16'h0001;
				end
			end
			sepd_pkg::EN_STATUS: begin
				tmr_nxt = tmr_r - 16'h0001;
				if (tmr_r == 16'h0001) begin
					latch_nxt = 1'b0;
					prot_lo_nxt = wd_r[`SEPD_PROT_LO_BIT];
					prot_hi_nxt = wd_r[`SEPD_PROT_HI_BIT];
					pin_gate_nxt = wd_r[`SEPD_PIN_GATE_BIT];
					eng_nxt = sepd_pkg::EN_IDLE;
				end
			end
			sepd_pkg::EN_SETTLE: begin
				tmr_nxt = tmr_r - 16'h0001;
				if (tmr_r == 16'h0001) begin
					eng_nxt = sepd_pkg::EN_IDLE;
				end
			end
			sepd_pkg::EN_RELEASE: begin
				tmr_nxt = tmr_r - 16'h0001;
				if (tmr_r == 16'h0001) begin
					dpd_nxt = 1'b0;
					eng_nxt = sepd_pkg::EN_IDLE;
				end
			end
			default: begin
				eng_nxt = sepd_pkg::EN_IDLE;
			end
		endcase
		busy_nxt = (eng_nxt == sepd_pkg::EN_ERASE) || (eng_nxt == sepd_pkg::EN_STATUS);
		// Standby: no frame open, engine idle, not powered down; a select held
		// low since power-up opens no frame, so it leaves standby alone
		sby_nxt = (ph_nxt == sepd_pkg::SP_IDLE) && (eng_nxt == sepd_pkg::EN_IDLE) && !dpd_nxt;
	end

	// ------------------------------------------------------------------------
	// Registers; reset gives standby, latch clear
	// ------------------------------------------------------------------------
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			ph_r <= sepd_pkg::SP_IDLE;
			eng_r <= sepd_pkg::EN_IDLE;
			cs_d_r <= 1'b0;
			sck_d_r <= 1'b0;
			cnt_r <= 6'h00;
			sh_r <= 8'h00;
			op_r <= 8'h00;
			out_r <= 8'h00;
			idx_r <= 3'h0;
			wd_r <= 8'h00;
			tmr_r <= 16'h0000;
			ea_r <= 16'h0000;
			so_r <= 1'b0;
			oe_r <= 1'b0;
			latch_r <= 1'b0;
			prot_lo_r <= 1'b0;
			prot_hi_r <= 1'b0;
			pin_gate_r <= 1'b0;
			dpd_r <= 1'b0;
			busy_r <= 1'b0;
			sby_r <= 1'b1;
		end else begin
			ph_r <= ph_nxt;
			eng_r <= eng_nxt;
			cs_d_r <= cs_d_nxt;
			sck_d_r <= sck_d_nxt;
			cnt_r <= cnt_nxt;
			sh_r <= sh_nxt;
			op_r <= op_nxt;
			out_r <= out_nxt;
			idx_r <= idx_nxt;
			wd_r <= wd_nxt;
			tmr_r <= tmr_nxt;
			ea_r <= ea_nxt;
			so_r <= so_nxt;
			oe_r <= oe_nxt;
			latch_r <= latch_nxt;
			prot_lo_r <= prot_lo_nxt;
			prot_hi_r <= prot_hi_nxt;
			pin_gate_r <= pin_gate_nxt;
			dpd_r <= dpd_nxt;
			busy_r <= busy_nxt;
			sby_r <= sby_nxt;
		end
	end

	// Array port; contents survive reset like real cells
	always_ff @(posedge clock) begin
		if (mem_we) begin
			mem[ea_r] <= mem_wd;
		end
		peek_r <= mem[peek_addr];
	end

	assign peek_data = peek_r;
	assign so_o = so_r;
	assign so_oe = oe_r;
	assign write_in_progress = busy_r;
	assign write_enable_latch = latch_r;
	assign block_protect_low = prot_lo_r;
	assign block_protect_high = prot_hi_r;
	assign status_write_protect_enable = pin_gate_r;
	assign deep_powerdown = dpd_r;
	assign standby = sby_r;

	// ------------------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------------------
	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);

	a_erase_fill: assert property (eng_r == sepd_pkg::EN_ERASE |-> mem_we && mem_wd == 8'hff)
		else $error("erase does not write ones");
	a_erase_gate: assert property (start_erase |-> latch_r && !prot_lo_r && !prot_hi_r && !dpd_r)
		else $error("erase started while protected");
	a_erase_busy: assert property (start_erase |=> busy_r && !sby_r)
		else $error("busy flag missing during erase");
	a_release_end: assert property (eng_r == sepd_pkg::EN_RELEASE && tmr_r == 16'h0001
		|=> !dpd_r && eng_r == sepd_pkg::EN_IDLE)
		else $error("release delay did not end power-down");
	a_so_float: assert property (pins.cs_n && $past(pins.cs_n) |=> !oe_r)
		else $error("output driven while deselected");
	a_wp_block: assert property (start_status |-> !(pin_gate_r && !pins.wp_n) && latch_r)
		else $error("status write passed protect pin");
	a_latch_clear: assert property (eng_r == sepd_pkg::EN_STATUS && tmr_r == 16'h0001
		|=> !latch_r && !busy_r)
		else $error("write latch not cleared");
	a_sig_order: assert property (sck_rise && ph_r == sepd_pkg::SP_SHIFT && op_r == OPC_SIG
		&& cnt_r == `SEPD_SIG_LAST |=> ph_r == sepd_pkg::SP_OUT && out_r == SIGNATURE)
		else $error("signature not staged after dummy bits");
	a_pd_silent: assert property (dpd_r && start_status == 1'b0 |-> !start_erase)
		else $error("erase accepted in power-down");
endmodule

// [bench/sepd_spi_master.sv]
/*
 * Bus master model for the serial memory: frames select, serial clock and data in.
 * Assumes a 40 ns core clock; one serial bit takes 8 core clocks, sent MSB first.
 */
`timescale 1ns/1ns
module sepd_spi_master (
	input wire logic clock,
	input wire logic so_line,
	output logic cs_n,
	output logic sck,
	output logic si
);
	initial begin
		cs_n = 1'b0;
		sck = 1'b0;
		si = 1'b0;
	end

	// Idle data line toggles, so a stale bit never passes for a good one
	always @(posedge clock) begin
		if (cs_n) begin
			si <= ~si;
		end
	end

	// ------------------------------------------------------------------
	// One framed transfer; the serial clock stands low outside frames
	// ------------------------------------------------------------------
	// deselect after last bit
	task automatic frame(input logic [39:0] tx, input int nbits, output logic [39:0] rx);
		rx = '0;
		@(posedge clock) cs_n <= 1'b0;
		repeat (3) @(posedge clock);
		for (int i = nbits - 1; i >= 0; i--) begin
			// drive with the fall, sample at rise; 8 clocks a bit
			@(posedge clock) begin
				sck <= 1'b0;
				si <= tx[i];
			end
			repeat (3) @(posedge clock);
			@(posedge clock) sck <= 1'b1;
			rx = {rx[38:0], so_line};
			repeat (3) @(posedge clock);
		end
		@(posedge clock) sck <= 1'b0;
		repeat (3) @(posedge clock);
		@(posedge clock) cs_n <= 1'b1;
	endtask
endmodule

// [bench/test_sepd_eeprom.sv]
/*
 * Self-checking bench for the serial memory slave with a bus master model.
 * Assumes the design defaults for opcodes and a 16-byte erase sweep.
 */
`timescale 1ns/1ns
module test_sepd_eeprom;
	logic clock = 1'b0;
	logic rst = 1'b1;
	logic wp_n_pin = 1'b1;
	logic [15:0] peek_addr = 16'h0000;
	logic [7:0] peek_data, wr, er, pd, sg, ws, rs;
	logic so_o, so_oe, write_in_progress, write_enable_latch, block_protect_low;
	logic block_protect_high, status_write_protect_enable, deep_powerdown, standby;
	logic cs_n, sck, si;
	logic [39:0] rx;
	logic [31:0] lfsr_r = 32'had84d505; // Random source, fixed start
	int miscompares = 0;
	int total_checks = 0;
	int oe_cnt = 0; // Cycles with output driven
	int base;
	string name_q[$];
	logic [15:0] exp_q[$], obs_q[$];
	wire so_line = so_oe ? so_o : 1'bz; // No pull: undriven reads as z

	always #20 clock = ~clock;

	sepd_eeprom #(.ERASE_BYTES(16)) u_sepd_eeprom (.clock(clock), .rst(rst),
		.cs_n_pin(cs_n), .sck_pin(sck), .si_pin(si), .wp_n_pin(wp_n_pin),
		.peek_addr(peek_addr), .peek_data(peek_data), .so_o(so_o), .so_oe(so_oe),
		.write_in_progress(write_in_progress), .write_enable_latch(write_enable_latch),
		.block_protect_low(block_protect_low), .block_protect_high(block_protect_high),
		.status_write_protect_enable(status_write_protect_enable),
		.deep_powerdown(deep_powerdown), .standby(standby));

	sepd_spi_master u_sepd_spi_master (.clock(clock), .so_line(so_line), .cs_n(cs_n),
		.sck(sck), .si(si));

	always @(posedge clock) begin
		if (so_oe === 1'b1) begin
			oe_cnt++;
		end
	end

	// ------------------------------------------------------------------
	// Notes, comparison and verdict
	// ------------------------------------------------------------------
	task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
		name_q.push_back(what);
		exp_q.push_back(exp);
		obs_q.push_back(got);
	endtask

	task automatic compare(input string what, input logic [15:0] exp, input logic [15:0] got);
		total_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("unexpected %s: expected %h, seen %h", what, exp, got);
		end
	endtask

	// Oldest note is paired with each result as it appears
	initial begin
		forever begin
			wait (obs_q.size() > 0);
			compare(name_q.pop_front(), exp_q.pop_front(), obs_q.pop_front());
		end
	end

	task automatic results();
		$display("checks %0d, miscompares %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	// Budget is several times the expected run, well under the cycle cap
	initial begin
		repeat (60000) @(posedge clock);
		miscompares++;
		results();
	end

	// ------------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------------
	function automatic logic [15:0] stat();
		return {8'h00, status_write_protect_enable, 3'h0, block_protect_high,
			block_protect_low, write_enable_latch, write_in_progress};
	endfunction

	// Next word of the random source
	function automatic logic [31:0] lfsr_next(input logic [31:0] v);
		return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction

	task automatic cmd(input logic [39:0] tx, input int n);
		u_sepd_spi_master.frame(tx, n, rx);
		repeat (8) @(posedge clock);
	endtask

	// Bounded wait for the internal cycle, then the release margin
	task automatic wait_idle();
		for (int i = 0; i < 400 && write_in_progress !== 1'b0; i++) @(posedge clock);
		repeat (30) @(posedge clock);
	endtask

	// ------------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------------
	initial begin
		wr = u_sepd_eeprom.OPC_WRITE_EN;
		rs = u_sepd_eeprom.OPC_RDSR;
		er = u_sepd_eeprom.OPC_ERASE;
		pd = u_sepd_eeprom.OPC_PD;
		sg = u_sepd_eeprom.OPC_SIG;
		ws = u_sepd_eeprom.OPC_WRSR;
		repeat (3) @(posedge clock);
		rst <= 1'b0;
		repeat (2) @(posedge clock);
		check("standby", 16'h0001, {15'h0, standby});
		check("output enable", 16'h0000, {15'h0, so_oe});
		cmd(40'(wr), 8);
		check("status", 16'h0000, stat());
		cmd({wr, 1'b1}, 9);
		check("status", 16'h0000, stat());
		cmd(40'(er), 8);
		check("status", 16'h0000, stat());
		cmd(40'(wr), 8);
		check("status", 16'h0002, stat());
		cmd({rs, 8'h00}, 16);
		check("status read", 16'h0002, {8'h00, rx[7:0]});
		cmd({er, 1'b0}, 9);
		check("status", 16'h0002, stat());
		$display("test framing done");
		for (int b = 1; b < 4; b++) begin
			cmd(40'(wr), 8);
			cmd({ws, 4'h0, 2'(b), 2'h0}, 16);
			wait_idle();
			check("status", 16'(b * 4), stat());
			cmd(40'(wr), 8);
			cmd(40'(er), 8);
			check("status", 16'(b * 4 + 2), stat());
			cmd({ws, 8'h00}, 16);
			wait_idle();
		end
		check("status", 16'h0000, stat());
		$display("test protect done");
		cmd(40'(wr), 8);
		cmd(40'(er), 8);
		check("status", 16'h0003, stat());
		check("standby", 16'h0000, {15'h0, standby});
		wait_idle();
		check("status", 16'h0000, stat());
		check("standby", 16'h0001, {15'h0, standby});
		for (int i = 0; i < 16; i++) begin
			lfsr_r = lfsr_next(lfsr_r);
			peek_addr <= {12'h000, lfsr_r[3:0]};
			repeat (2) @(posedge clock);
			check("array byte", 16'h00ff, {8'h00, peek_data});
		end
		$display("test erase done");
		cmd(40'(wr), 8);
		cmd({ws, 8'h80}, 16);
		wait_idle();
		@(posedge clock) wp_n_pin <= 1'b0;
		cmd(40'(wr), 8);
		cmd({ws, 8'h00}, 16);
		wait_idle();
		check("status", 16'h0082, stat());
		@(posedge clock) wp_n_pin <= 1'b1;
		cmd({ws, 8'h00}, 16);
		@(posedge clock) wp_n_pin <= 1'b0;
		base = oe_cnt;
		cmd({sg, 32'h0}, 40);
		check("output cycles", 16'h0000, 16'(oe_cnt - base));
		wait_idle();
		check("status", 16'h0000, stat());
		@(posedge clock) wp_n_pin <= 1'b1;
		$display("test write protect done");
		lfsr_r = lfsr_next(lfsr_r);
		cmd({sg, lfsr_r[15:0], 16'h0}, 40);
		check("signature", {2{u_sepd_eeprom.SIGNATURE}}, rx[15:0]);
		check("output enable", 16'h0000, {15'h0, so_oe});
		cmd({pd, 1'b0}, 9);
		check("powerdown", 16'h0001, {14'h0, deep_powerdown, standby});
		cmd(40'(pd), 8);
		check("powerdown", 16'h0002, {14'h0, deep_powerdown, standby});
		repeat (30) @(posedge clock);
		cmd(40'(wr), 8);
		check("status", 16'h0000, stat());
		lfsr_r = lfsr_next(lfsr_r);
		cmd({sg, lfsr_r[15:0], 16'h0}, 40);
		check("signature", {2{u_sepd_eeprom.SIGNATURE}}, rx[15:0]);
		repeat (40) @(posedge clock);
		check("powerdown", 16'h0001, {14'h0, deep_powerdown, standby});
		cmd(40'(pd), 8);
		repeat (30) @(posedge clock);
		cmd(40'(sg), 8);
		check("powerdown", 16'h0002, {14'h0, deep_powerdown, standby});
		repeat (40) @(posedge clock);
		check("powerdown", 16'h0001, {14'h0, deep_powerdown, standby});
		$display("test power-down done");
		wait (obs_q.size() == 0);
		#1;
		results();
	end
endmodule
